/* design/dpr_cfg.svh */
// constants for the dual-port ram port controller: timing figures, counts, pin encodings
// assumes a 10 ns controller clock; the count macros depend on it
`ifndef DPR_CFG_SVH
`define DPR_CFG_SVH

`define DPR_CLK_NS          10
// access and arbitration figures in ns (slowest speed grade)
`define DPR_SEL_ACC_NS      25
`define DPR_OE_ACC_NS       13
`define DPR_BUSY_ADDR_NS    25
`define DPR_BUSY_SEL_NS     25
`define DPR_FLOW_NS         35
`define DPR_TOK_REC_NS      15
`define DPR_TOK_WRRD_NS     15
`define DPR_WR_SETUP_NS     15
`define DPR_WR_PULSE_NS     25
// least times round up to whole cycles
`define DPR_CYC(ns)         (((ns) + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`define DPR_MAX(a, b)       (((a) > (b)) ? (a) : (b))
`define DPR_SETTLE_CYC      `DPR_CYC(`DPR_MAX(`DPR_BUSY_ADDR_NS, `DPR_BUSY_SEL_NS))
`define DPR_READ_CYC        `DPR_CYC(`DPR_MAX(`DPR_SEL_ACC_NS, `DPR_OE_ACC_NS) + `DPR_FLOW_NS)
`define DPR_WRITE_CYC       `DPR_CYC(`DPR_MAX(`DPR_WR_PULSE_NS, `DPR_WR_SETUP_NS))
`define DPR_TOK_REC_CYC     `DPR_CYC(`DPR_MAX(`DPR_TOK_REC_NS, `DPR_TOK_WRRD_NS))
`define DPR_SYNC_CYC        2
// mailbox words: right owns the top word, left the one below
`define DPR_MBOX_R_32K      16'h7FFF
`define DPR_MBOX_L_32K      16'h7FFE
`define DPR_MBOX_R_64K      16'hFFFF
`define DPR_MBOX_L_64K      16'hFFFE
`define DPR_TOK_ADDR_W      3
`define DPR_DATA_W          18
`define DPR_ADDR_W          16

`endif

/* design/dpr_pkg.sv */
// types shared by the dual-port ram port controller
// assumes dpr_cfg.svh is compiled alongside
package dpr_pkg;

    typedef enum logic [1:0] {
        DPR_MEM_RD = 2'h0,
        DPR_MEM_WR = 2'h1,
        DPR_TOK_RD = 2'h2,
        DPR_TOK_WR = 2'h3
    } dpr_cmd_t;

    typedef struct packed {
        dpr_cmd_t    cmd;
        logic [15:0] addr;
        logic [17:0] data;
        logic [1:0]  be;
    } dpr_req_t;

    typedef enum logic [4:0] {
        DPR_IDLE    = 5'h01,
        DPR_SETTLE  = 5'h02,
        DPR_STROBE  = 5'h04,
        DPR_CAPTURE = 5'h08,
        DPR_RECOVER = 5'h10
    } dpr_state_t;

endpackage

/* design/dpr_port_ctrl.sv */
// host-side controller for one port of an asynchronous dual-port ram
// assumes the ram pins are wired straight to the PIN ports; DQ is resolved outside
// Operation
// - reads wait the cross-port flow-through delay before sampling data.
// - memory read asserts chip enable and output enable, samples after access delay.
// - token read asserts token select and output enable, chip enable stays high.
// - memory writes held off until busy has settled after enable; token writes skip the settle wait.
// - token access uses token select low with chip enable high.
// - after token write, select released for recovery before read-back.
`timescale 1ns/1ns
`include "dpr_cfg.svh"

module dpr_port_ctrl
    import dpr_pkg::*;
#(
    parameter logic IS_RIGHT = 1'b0,
    parameter logic IS_64K   = 1'b0
) (
    input  wire logic        CLOCK,
    input  wire logic        RESETN,
    input  wire logic        REQ_VALID,
    input  wire dpr_req_t    REQ,
    output logic             REQ_READY,
    output logic             DONE,
    output logic             DONE_BUSY,
    output logic [17:0]      RD_DATA,
    output logic             MAIL_PENDING,
    output logic [15:0]      OWN_MBOX,
    output logic [15:0]      PIN_ADDR,
    output logic             PIN_CE0_N,
    output logic             PIN_CE1,
    output logic             PIN_RW_N,
    output logic             PIN_OE_N,
    output logic             PIN_TOKEN_SELECT_N,
    output logic             PIN_HIGH_BYTE_SEL_N,
    output logic             PIN_LOW_BYTE_SEL_N,
    output logic [17:0]      PIN_DQ_O,
    output logic             PIN_DQ_OE_N,
    input  wire logic [17:0] PIN_DQ_I,
    input  wire logic        PIN_BUSY_N,
    input  wire logic        PIN_INT_N
);

    // mailbox decode, used for the own word only
    function automatic logic [15:0] mbox_addr(input logic right, input logic big);
        logic [15:0] a;
        a = 16'h0000;
        if (big) begin
            a = right ? `DPR_MBOX_R_64K : `DPR_MBOX_L_64K;
        end else begin
            a = right ? `DPR_MBOX_R_32K : `DPR_MBOX_L_32K;
        end
        return a;
    endfunction

    localparam logic [7:0] SETTLE_C = 8'(`DPR_SETTLE_CYC + `DPR_SYNC_CYC);
    localparam logic [7:0] READ_C   = 8'(`DPR_READ_CYC);
    localparam logic [7:0] WRITE_C  = 8'(`DPR_WRITE_CYC);
    localparam logic [7:0] TOKREC_C = 8'(`DPR_TOK_REC_CYC);
    localparam logic [7:0] SYNC_C   = 8'(`DPR_SYNC_CYC);

    dpr_state_t  state_q, state_d;
    dpr_req_t    req_q;
    logic [7:0]  cnt_q, cnt_d;
    logic        busy_s1_q, busy_s2_q, int_s1_q, int_s2_q;
    logic [17:0] dq_s1_q, dq_s2_q;
    logic        ready_q, done_q, done_busy_q, mail_q;
    logic [17:0] rd_data_q;
    logic [15:0] addr_q;
    logic        ce0_n_q, rw_n_q, oe_n_q, tok_n_q, hi_n_q, lo_n_q, dq_oe_n_q;
    logic [17:0] dq_o_q;

    // request decode
    wire logic        take     = REQ_VALID && ready_q;
    wire logic        is_tok   = req_q.cmd[1];
    wire logic        is_wr    = req_q.cmd[0];
    wire logic        busy_now = !busy_s2_q;
    wire logic        cnt_zero = (cnt_q == 8'h00);
    wire logic [7:0]  cnt_dec  = cnt_q - 8'h01;
    wire logic        new_tok  = REQ.cmd[1];
    wire logic        new_wr   = REQ.cmd[0];
    // token accesses see only the low three address bits
    wire logic [15:0] pin_addr = new_tok ? {13'h0000, REQ.addr[2:0]} : REQ.addr;
    wire logic [17:0] wr_word  = is_tok ? {17'h00000, req_q.data[0]} : req_q.data;
    wire logic        abort_wr = is_wr && !is_tok && busy_now;

    // two-stage sync of the asynchronous pins; only stage two is read
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            busy_s1_q <= 1'b1;
            busy_s2_q <= 1'b1;
            int_s1_q  <= 1'b1;
            int_s2_q  <= 1'b1;
            dq_s1_q   <= 18'h00000;
            dq_s2_q   <= 18'h00000;
        end else begin
            busy_s1_q <= PIN_BUSY_N;
            busy_s2_q <= busy_s1_q;
            int_s1_q  <= PIN_INT_N;
            int_s2_q  <= int_s1_q;
            dq_s1_q   <= PIN_DQ_I;
            dq_s2_q   <= dq_s1_q;
        end
    end

    // sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_zero ? cnt_q : cnt_dec;
        case (state_q)
            DPR_IDLE: begin
                if (take) begin
                    state_d = DPR_SETTLE;
                    cnt_d   = new_tok ? 8'h00 : SETTLE_C;
                end
            end
            DPR_SETTLE: begin
                if (cnt_zero) begin
                    state_d = abort_wr ? DPR_RECOVER : DPR_STROBE;
                    cnt_d   = abort_wr ? 8'h00 : (is_wr ? WRITE_C : READ_C);
                end
            end
            DPR_STROBE: begin
                if (cnt_zero) begin
                    state_d = is_wr ? DPR_RECOVER : DPR_CAPTURE;
                    cnt_d   = is_wr ? (is_tok ? TOKREC_C : 8'h00) : SYNC_C;
                end
            end
            DPR_CAPTURE: begin
                if (cnt_zero) begin
                    state_d = DPR_RECOVER;
                    cnt_d   = 8'h00;
                end
            end
            DPR_RECOVER: begin
                if (cnt_zero) begin
                    state_d = DPR_IDLE;
                end
            end
            default: begin
                state_d = DPR_IDLE;
                cnt_d   = 8'h00;
            end
        endcase
    end

    // state, request latch and user-side flags
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            state_q     <= DPR_IDLE;
            cnt_q       <= 8'h00;
            req_q       <= '0;
            ready_q     <= 1'b0;
            done_q      <= 1'b0;
            done_busy_q <= 1'b0;
            rd_data_q   <= 18'h00000;
            mail_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            ready_q     <= (state_d == DPR_IDLE) && !take;
            done_q      <= (state_d == DPR_RECOVER) && (state_q != DPR_RECOVER);
            mail_q      <= !int_s2_q;
            if (take) begin
                req_q <= REQ;
            end
            if (state_q == DPR_SETTLE && cnt_zero) begin
                done_busy_q <= busy_now;
            end
            if (state_q == DPR_CAPTURE && cnt_zero) begin
                rd_data_q <= dq_s2_q;
            end
        end
    end

    // pin drive; every strobe comes from a flop so edges are glitch free
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            addr_q    <= 16'h0000;
            ce0_n_q   <= 1'b1;
            rw_n_q    <= 1'b1;
            oe_n_q    <= 1'b1;
            tok_n_q   <= 1'b1;
            hi_n_q    <= 1'b1;
            lo_n_q    <= 1'b1;
            dq_o_q    <= 18'h00000;
            dq_oe_n_q <= 1'b1;
        end else begin
            if (take) begin
                addr_q  <= pin_addr;
                ce0_n_q <= new_tok;
                tok_n_q <= !new_tok;
                oe_n_q  <= new_wr;
                hi_n_q  <= !(new_tok || REQ.be[1]);
                lo_n_q  <= !(new_tok || REQ.be[0]);
            end
            if (state_q == DPR_SETTLE && cnt_zero && is_wr && !abort_wr) begin
                rw_n_q    <= 1'b0;
                dq_o_q    <= wr_word;
                dq_oe_n_q <= 1'b0;
            end
            if (state_q == DPR_SETTLE && cnt_zero && abort_wr) begin
                ce0_n_q <= 1'b1;
                tok_n_q <= 1'b1;
            end
            // strobe rises first; data and selects drop one cycle later for hold
            if (state_q == DPR_STROBE && cnt_zero && is_wr) begin
                rw_n_q <= 1'b1;
            end
            if (state_q == DPR_CAPTURE && cnt_zero) begin
                ce0_n_q <= 1'b1;
                tok_n_q <= 1'b1;
                oe_n_q  <= 1'b1;
            end
            if (state_q == DPR_RECOVER) begin
                ce0_n_q   <= 1'b1;
                tok_n_q   <= 1'b1;
                oe_n_q    <= 1'b1;
                hi_n_q    <= 1'b1;
                lo_n_q    <= 1'b1;
                dq_oe_n_q <= 1'b1;
            end
        end
    end

    assign REQ_READY           = ready_q;
    assign DONE                = done_q;
    assign DONE_BUSY           = done_busy_q;
    assign RD_DATA             = rd_data_q;
    assign MAIL_PENDING        = mail_q;
    assign OWN_MBOX            = mbox_addr(IS_RIGHT, IS_64K);
    assign PIN_ADDR            = addr_q;
    assign PIN_CE0_N           = ce0_n_q;
    assign PIN_CE1             = 1'b1;  // second enable held active, first one steers
    assign PIN_RW_N            = rw_n_q;
    assign PIN_OE_N            = oe_n_q;
    assign PIN_TOKEN_SELECT_N  = tok_n_q;
    assign PIN_HIGH_BYTE_SEL_N = hi_n_q;
    assign PIN_LOW_BYTE_SEL_N  = lo_n_q;
    assign PIN_DQ_O            = dq_o_q;
    assign PIN_DQ_OE_N         = dq_oe_n_q;

endmodule

/* verif/dpr_port_ctrl_asserts.sv */
// pin-level assertions for one ram port controller
// assumes binding to dpr_port_ctrl; sees its ports only
`timescale 1ns/1ns
module dpr_port_ctrl_asserts
    import dpr_pkg::*;
(
    input wire logic        CLOCK,
    input wire logic        RESETN,
    input wire logic        DONE,
    input wire logic        DONE_BUSY,
    input wire logic        MAIL_PENDING,
    input wire logic [15:0] PIN_ADDR,
    input wire logic        PIN_CE0_N,
    input wire logic        PIN_RW_N,
    input wire logic        PIN_OE_N,
    input wire logic        PIN_TOKEN_SELECT_N,
    input wire logic [17:0] PIN_DQ_O,
    input wire logic        PIN_DQ_OE_N,
    input wire logic        PIN_BUSY_N,
    input wire logic        PIN_INT_N
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    property p_read_sel; !PIN_OE_N |-> PIN_CE0_N != PIN_TOKEN_SELECT_N; endproperty
    a_read_sel: assert property (p_read_sel)
        else $error("output enable without one select");
    property p_tok_ce; !PIN_TOKEN_SELECT_N |-> PIN_CE0_N; endproperty
    a_tok_ce: assert property (p_tok_ce)
        else $error("token select with chip enable");
    property p_tok_addr; !PIN_TOKEN_SELECT_N |-> PIN_ADDR[15:3] == 13'h0000; endproperty
    a_tok_addr: assert property (p_tok_addr)
        else $error("token address upper bits set");
    property p_tok_data; !PIN_TOKEN_SELECT_N && !PIN_RW_N |-> PIN_DQ_O[17:1] == 17'h00000;
    endproperty
    a_tok_data: assert property (p_tok_data)
        else $error("token write uses more than bit 0");
    property p_wr_hold; $rose(PIN_RW_N) |-> !PIN_DQ_OE_N && $stable(PIN_DQ_O); endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write data not held past strobe");
    // busy needs 25 ns plus two sync stages before a write may start
    property p_settle; $fell(PIN_CE0_N) |-> PIN_RW_N [*5]; endproperty
    a_settle: assert property (p_settle)
        else $error("write started before busy settled");
    // busy pin is judged three edges before the strobe falls: two sync stages plus decode
    property p_busy_gate; $fell(PIN_RW_N) && !PIN_CE0_N |-> $past(PIN_BUSY_N, 3); endproperty
    a_busy_gate: assert property (p_busy_gate)
        else $error("write driven while busy");
    property p_pending; $stable(PIN_INT_N) [*5] |-> MAIL_PENDING == !PIN_INT_N; endproperty
    a_pending: assert property (p_pending)
        else $error("pending flag does not follow interrupt");
    // reads hold output enable through access, flow-through and sync wait
    property p_rd_wait; $fell(PIN_OE_N) |-> !PIN_OE_N [*8]; endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read ended before data could settle");

    c_abort: cover property (DONE && DONE_BUSY);
    c_tok: cover property ($fell(PIN_TOKEN_SELECT_N));
    c_pend: cover property ($rose(MAIL_PENDING));
endmodule

bind dpr_port_ctrl dpr_port_ctrl_asserts u_dpr_port_ctrl_asserts (.*);

/* verif/dpr_ram_model.sv */
// behavioural 32K-word ram seen from its left port, slave mode
// assumes the bench acts as busy master and calls far-side tasks
`timescale 1ns/1ns
module dpr_ram_model #(
    parameter int DLY = 20
) (
    input  wire logic [15:0] addr,
    input  wire logic        ce_n,
    input  wire logic        rw_n,
    input  wire logic        oe_n,
    input  wire logic        tok_n,
    input  wire logic        hb_n,
    input  wire logic        lo_n,
    input  wire logic        busy_n,
    input  wire logic [17:0] dq_i,
    output wire logic [17:0] dq_o,
    output logic             int_n
);
    logic [17:0] mem [0:32767];
    logic [17:0] last_q = 18'h00000;
    logic [17:0] tok_q = 18'h00000;
    logic [17:0] dq_c;
    logic [7:0]  own [2] = '{8'h00, 8'h00};
    logic [7:0]  pend [2] = '{8'h00, 8'h00};
    logic        far_int_n = 1'b1;
    initial int_n = 1'b1;
    initial foreach (mem[i]) mem[i] = 18'h00000;

    // zero requests, one releases and hands over to a waiting request
    task automatic tok_wr(input int s, input logic [2:0] i, input logic b);
        if (!b && !own[0][i] && !own[1][i]) own[s][i] = 1'b1;
        else if (!b && !own[s][i]) pend[s][i] = 1'b1;
        else if (b && own[s][i]) begin
            own[s][i] = 1'b0;
            {own[1-s][i], pend[1-s][i]} = {pend[1-s][i], 1'b0};
        end
        else if (b) pend[s][i] = 1'b0;
    endtask
    task automatic far_wr(input logic [14:0] a, input logic [17:0] d);
        mem[a] = d;
        if (a == 15'h7FFE) int_n = 1'b0;
    endtask

    // writes land on the rising strobe; a busy port loses its memory write, token writes still land
    always @(posedge rw_n) begin
        if (!ce_n && busy_n) begin
            mem[addr[14:0]] = {hb_n ? mem[addr[14:0]][17:9] : dq_i[17:9],
                               lo_n ? mem[addr[14:0]][8:0] : dq_i[8:0]};
            if (addr[14:0] == 15'h7FFF) far_int_n = 1'b0;
        end
        if (!tok_n) tok_wr(0, addr[2:0], dq_i[0]);
    end
    // read side effects wait 1 ns so that all selects have landed
    always @(negedge oe_n or negedge ce_n or negedge tok_n) begin
        #1;
        if (!oe_n && !tok_n) tok_q = {18{!own[0][addr[2:0]]}};
        if (!oe_n && !ce_n) last_q = mem[addr[14:0]];
        if (!oe_n && !ce_n && busy_n && addr[14:0] == 15'h7FFE) int_n = 1'b1;
    end
    // released lanes show the inverse of the last word, never a stale copy
    always_comb begin
        dq_c = ~last_q;
        if (!oe_n && !tok_n) dq_c = tok_q;
        if (!oe_n && !ce_n) dq_c = {hb_n ? ~last_q[17:9] : mem[addr[14:0]][17:9],
                                    lo_n ? ~last_q[8:0] : mem[addr[14:0]][8:0]};
    end
    assign #(DLY) dq_o = dq_c;
endmodule

/* verif/dpr_port_ctrl_tb.sv */
// self-checking bench for the left-port controller of a 32K-word ram
// assumes dpr_ram_model on the pins; the bench plays the busy master
`timescale 1ns/1ns
module dpr_port_ctrl_tb
    import dpr_pkg::*;
;
    logic        clock;
    logic        resetn;
    logic        req_valid;
    logic        busy_n;
    dpr_req_t    req;
    logic        req_ready, done, done_busy, mail_pending, ce0_n, ce1, rw_n, oe_n;
    logic        tok_n, hb_n, lo_n, dq_oe_n, int_n;
    logic [17:0] rd_data, dq_o, ram_dq;
    logic [15:0] own_mbox, pin_addr;
    wire  [17:0] dq_bus = dq_oe_n ? ram_dq : dq_o;
    int          err_total = 0;
    int          cmp_count = 0;

    dpr_port_ctrl u_dpr_port_ctrl (
        .CLOCK(clock), .RESETN(resetn), .REQ_VALID(req_valid), .REQ(req),
        .REQ_READY(req_ready), .DONE(done), .DONE_BUSY(done_busy), .RD_DATA(rd_data),
        .MAIL_PENDING(mail_pending), .OWN_MBOX(own_mbox), .PIN_ADDR(pin_addr),
        .PIN_CE0_N(ce0_n), .PIN_CE1(ce1), .PIN_RW_N(rw_n), .PIN_OE_N(oe_n),
        .PIN_TOKEN_SELECT_N(tok_n), .PIN_HIGH_BYTE_SEL_N(hb_n), .PIN_LOW_BYTE_SEL_N(lo_n),
        .PIN_DQ_O(dq_o), .PIN_DQ_OE_N(dq_oe_n), .PIN_DQ_I(dq_bus), .PIN_BUSY_N(busy_n),
        .PIN_INT_N(int_n));
    dpr_ram_model u_dpr_ram_model (
        .addr(pin_addr), .ce_n(ce0_n | ~ce1), .rw_n(rw_n), .oe_n(oe_n), .tok_n(tok_n),
        .hb_n(hb_n), .lo_n(lo_n), .busy_n(busy_n), .dq_i(dq_bus), .dq_o(ram_dq),
        .int_n(int_n));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic chk(input string nm, input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one request, busy held for its whole length; samples at falling edges
    task automatic xfer(input dpr_cmd_t c, input logic [15:0] a, input logic [17:0] d,
                        input logic [1:0] be, input logic bz);
        int n;
        n = 0;
        @(posedge clock);
        req <= '{c, a, d, be};
        busy_n <= bz;
        req_valid <= 1'b1;
        do @(negedge clock); while (req_ready !== 1'b1 && ++n < 40);
        @(posedge clock);
        req_valid <= 1'b0;
        do @(negedge clock); while (done !== 1'b1 && ++n < 80);
        chk("done", {17'h00000, done}, 18'h00001);
    endtask
    task automatic wait_pend(input logic exp);
        for (int n = 0; n < 12 && mail_pending !== exp; n++) @(negedge clock);
        chk("pending", {17'h00000, mail_pending}, {17'h00000, exp});
    endtask
    // byte lanes, then a busy write that must leave the word alone
    task automatic s_mem();
        xfer(DPR_MEM_WR, 16'h0123, 18'h2A5A5, 2'h3, 1'b1);
        chk("no_abort", {17'h00000, done_busy}, 18'h00000);
        xfer(DPR_MEM_WR, 16'h0123, 18'h1C3C3, 2'h1, 1'b1);
        xfer(DPR_MEM_WR, 16'h0123, 18'h00000, 2'h3, 1'b0);
        chk("abort", {17'h00000, done_busy}, 18'h00001);
        xfer(DPR_MEM_RD, 16'h0123, 18'h00000, 2'h3, 1'b1);
        chk("mem", rd_data, 18'h2A5C3);
    endtask
    task automatic s_mbox();
        chk("own_mbox", {2'h0, own_mbox}, 18'h07FFE);
        u_dpr_ram_model.far_wr(15'h7FFE, 18'h00ABC);
        wait_pend(1'b1);
        xfer(DPR_MEM_RD, 16'h7FFF, 18'h00000, 2'h3, 1'b1);
        xfer(DPR_MEM_RD, own_mbox, 18'h00000, 2'h3, 1'b0);
        wait_pend(1'b1);
        chk("mbox", rd_data, 18'h00ABC);
        xfer(DPR_MEM_RD, own_mbox, 18'h00000, 2'h3, 1'b1);
        wait_pend(1'b0);
        xfer(DPR_MEM_WR, 16'h7FFF, 18'h00055, 2'h3, 1'b0);
        chk("far_int", {17'h00000, u_dpr_ram_model.far_int_n}, 18'h00001);
        xfer(DPR_MEM_WR, 16'h7FFF, 18'h00055, 2'h3, 1'b1);
        chk("far_int", {17'h00000, u_dpr_ram_model.far_int_n}, 18'h00000);
    endtask
    // upper address bits and data bits above 0 must not matter
    task automatic s_tok();
        xfer(DPR_TOK_WR, 16'hFFF5, 18'h3FFFE, 2'h3, 1'b1);
        xfer(DPR_TOK_RD, 16'h0005, 18'h00000, 2'h3, 1'b1);
        chk("tok_own", rd_data, 18'h00000);
        chk("tok_far", {17'h00000, ~u_dpr_ram_model.own[1][5]}, 18'h00001);
        u_dpr_ram_model.tok_wr(1, 3'h5, 1'b0);
        xfer(DPR_TOK_WR, 16'h0005, 18'h00001, 2'h3, 1'b1);
        xfer(DPR_TOK_RD, 16'h0005, 18'h00000, 2'h3, 1'b1);
        chk("tok_pass", rd_data, 18'h3FFFF);
        chk("tok_far", {17'h00000, ~u_dpr_ram_model.own[1][5]}, 18'h00000);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        req_valid = 1'b0;
        busy_n = 1'b1;
        req = '0;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        s_mem();
        s_mbox();
        s_tok();
        close_out();
    end
endmodule
